// ===== hdl/obc_defines.svh
/*
  Constants for the configuration byte loader: flash locations, field
  positions, codes and timing counts.
  Assumes inclusion by bare name from the package and the design modules.
*/
// Functional notes
// - Byte0 bits 6:5 give window: 25, 50, 75, 100 percent.
// - Byte0 bit 4 enables watchdog counting.
// - Byte0 bits 3:1 select overflow 2^7..2^17 slow clock cycles.
// - Byte0 bit 0 clear lets software stop the slow oscillator.
// - Stoppable slow oscillator: no watchdog clock in halt or stop.
// - Watchdog keeps counting during self-programming and emulation.
// - Byte1 bit 0 sets voltage detector default on at power-up.
// - Voltage default bit writable only by external programmer.
// - Boot swap copies alternate byte1 into primary byte1 location.
// - Voltage default changes only after whole-chip erase.
// - Byte2 bit 0 selects fast oscillator: 0 is 8 MHz, 1 is 4 MHz.
// - Byte3 bit 1 picks debug pins: 1 oscillator pins, 0 port pins.
// - Byte4 bits 1:0: off, prohibited, on, on with erase on failure.
// - Boot swap fetches every byte from the alternate location.
// - All five bytes are read and applied during reset processing.
// - Five consecutive bytes from primary base; swap moves to alternate.
`ifndef OBC_DEFINES_SVH
`define OBC_DEFINES_SVH

`define OBC_PRI_BASE 16'h0080
`define OBC_ALT_BASE 16'h1080
`define OBC_NUM_BYTES 3'h5
`define OBC_WB_ADDR_W 8
// Register word offsets of the five bytes and status (byte offset = 4 x index)
`define OBC_REG_WDT 8'h80
`define OBC_REG_LVD 8'h81
`define OBC_REG_FOSC 8'h82
`define OBC_REG_DBGPIN 8'h83
`define OBC_REG_DBGCTL 8'h84
`define OBC_REG_STATUS 8'h90
// Field positions
`define OBC_WIN_HI 6
`define OBC_WIN_LO 5
`define OBC_WDT_EN 4
`define OBC_WDCS_HI 3
`define OBC_WDCS_LO 1
`define OBC_LOCK_BIT 0
`define OBC_LVD_BIT 0
`define OBC_FOSC_BIT 0
`define OBC_PIN_BIT 1
`define OBC_DBG_EN 1
`define OBC_DBG_ERASE 0
// Reset value (raw byte registers before fetch)
`define OBC_BYTE_RST 8'h00
// Fixed-pattern masks for programming checks
`define OBC_B3_MASK 8'hfd
`define OBC_B3_FIXED 8'h1c
// Flash read latency in clk cycles
`define OBC_FLASH_LAT 2'h1
`endif

// ===== hdl/obc_pkg.sv
/*
  Types for the configuration byte loader.
  Assumes obc_defines.svh is on the include path.
*/
`include "obc_defines.svh"
package obc_pkg;
  typedef enum logic [1:0] {OBC_WIN_25, OBC_WIN_50, OBC_WIN_75, OBC_WIN_100} obc_win_t;
  typedef enum logic [1:0] {OBC_DBG_OFF, OBC_DBG_BAD, OBC_DBG_KEEP, OBC_DBG_WIPE} obc_dbg_t;
  typedef enum {OBC_IDLE, OBC_REQ, OBC_WAIT, OBC_DONE} obc_state_t;

  // Decoded settings handed to consumer units
  typedef struct packed {
    obc_win_t wdt_window;
    logic wdt_run_enable;
    logic [2:0] wdt_period_sel;
    logic [4:0] wdt_ovf_log2;
    logic slow_osc_lock;
    logic voltage_detect_default_on;
    logic fast_osc_freq_sel;
    logic debug_pin_pair_sel;
    obc_dbg_t debug_mode;
    logic debug_enable;
    logic debug_erase_on_fail;
  } obc_cfg_t;

  // Flash read request and answer
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } obc_flash_req_t;

  typedef struct packed {
    logic ready;
    logic [7:0] data;
  } obc_flash_rsp_t;

  // Classic Wishbone slave signals
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [`OBC_WB_ADDR_W-1:0] adr;
    logic [31:0] dat;
  } obc_wb_req_t;
endpackage : obc_pkg

// ===== hdl/obc_byte_decode.sv
/*
  Combinational decoder from the five raw configuration bytes to settings.
  Assumes bytes are stable once the loader has finished fetching.
*/
`timescale 1ns/1ps
`include "obc_defines.svh"
module obc_byte_decode
  import obc_pkg::*;
(
  input wire logic [7:0] byte0_i, // Watchdog and slow oscillator byte
  input wire logic [7:0] byte1_i, // Voltage detector byte
  input wire logic [7:0] byte2_i, // Fast oscillator byte
  input wire logic [7:0] byte3_i, // Debug pin byte
  input wire logic [7:0] byte4_i, // Debug control byte
  output obc_pkg::obc_cfg_t cfg_o, // Decoded settings
  output logic pattern_err_o // Fixed bits or prohibited codes seen
);
  import obc_pkg::*;

  // Overflow code to power-of-two exponent
  function automatic logic [4:0] ovf_log2(input logic [2:0] sel);
    case (sel)
      3'h0: ovf_log2 = 5'h07;
      3'h1: ovf_log2 = 5'h08;
      3'h2: ovf_log2 = 5'h09;
      3'h3: ovf_log2 = 5'h0a;
      3'h4: ovf_log2 = 5'h0c;
      3'h5: ovf_log2 = 5'h0e;
      3'h6: ovf_log2 = 5'h0f;
      default: ovf_log2 = 5'h11;
    endcase
  endfunction : ovf_log2

  // Field extraction
  always_comb
  begin
    cfg_o.wdt_window = obc_win_t'(byte0_i[`OBC_WIN_HI:`OBC_WIN_LO]);
    cfg_o.wdt_run_enable = byte0_i[`OBC_WDT_EN];
    cfg_o.wdt_period_sel = byte0_i[`OBC_WDCS_HI:`OBC_WDCS_LO];
    cfg_o.wdt_ovf_log2 = ovf_log2(byte0_i[`OBC_WDCS_HI:`OBC_WDCS_LO]);
    cfg_o.slow_osc_lock = byte0_i[`OBC_LOCK_BIT];
    cfg_o.voltage_detect_default_on = byte1_i[`OBC_LVD_BIT];
    cfg_o.fast_osc_freq_sel = byte2_i[`OBC_FOSC_BIT];
    cfg_o.debug_pin_pair_sel = byte3_i[`OBC_PIN_BIT];
    cfg_o.debug_mode = obc_dbg_t'(byte4_i[1:0]);
    // Prohibited code 01 treated as disabled, the safe reading
    cfg_o.debug_enable = byte4_i[`OBC_DBG_EN];
    cfg_o.debug_erase_on_fail = byte4_i[`OBC_DBG_EN] & byte4_i[`OBC_DBG_ERASE];
  end

  // Flags programming slips; hardware decodes regardless
  assign pattern_err_o = byte0_i[7]
    | ((byte0_i[6:1] & 6'h37) == 6'h00)
    | (byte1_i[7:1] != 7'h00) | (byte2_i[7:1] != 7'h00)
    | ((byte3_i & `OBC_B3_MASK) != `OBC_B3_FIXED)
    | (byte4_i[7:2] != 6'h00) | (byte4_i[1:0] == 2'h1);
endmodule : obc_byte_decode

// ===== hdl/obc_loader.sv
/*
  Reset-time loader of the five configuration bytes, with watchdog and
  oscillator gating, programmer write gate and Wishbone read-back.
  Assumes a byte-wide flash read port answering with a ready pulse, and
  power-mode, programming-mode and swap inputs from the system controller.
*/
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "obc_defines.svh"
module obc_loader
  import obc_pkg::*;
(
  input wire logic clk_i, // System clock, 25 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic boot_swap_i, // Boot swap active
  output obc_pkg::obc_flash_req_t flash_req_o, // Flash byte read request
  input wire obc_pkg::obc_flash_rsp_t flash_rsp_i, // Flash byte answer
  output logic cfg_valid_o, // Settings applied, reset may end
  output obc_pkg::obc_cfg_t cfg_o, // Decoded settings
  input wire logic halt_i, // CPU in halt mode
  input wire logic stop_i, // CPU in stop mode
  input wire logic slow_osc_stop_req_i, // Software stop request
  input wire logic flash_selfprog_i, // Self-programming or emulation busy
  output logic slow_osc_run_o, // Slow oscillator enable
  output logic wdt_clk_en_o, // Watchdog count clock gate
  input wire logic ext_prog_mode_i, // Dedicated programmer attached
  input wire logic chip_erased_i, // Whole-chip erase since last write
  input wire logic lvd_wr_req_i, // Attempt to write voltage default
  output logic lvd_wr_allow_o, // Voltage default write accepted
  output logic swap_copy_o, // Copy alternate byte1 to primary
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [3:0] wb_sel_i, // Wishbone byte select
  input wire logic [`OBC_WB_ADDR_W-1:0] wb_adr_i, // Word index
  input wire logic [31:0] wb_dat_i, // Write data, ignored
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic wb_err_o // Unmapped or write access
);
  import obc_pkg::*;

  typedef struct packed {
    obc_state_t state;
    logic [2:0] idx;
    logic swap;
    logic [4:0][7:0] bytes;
    logic valid;
    logic ack;
    logic err;
    logic [31:0] rdat;
  } obc_regs_t;

  obc_regs_t r;
  obc_regs_t next_r;
  obc_cfg_t dec_cfg;
  logic pattern_err;

  // Raw bytes are decoded continuously; the decoder holds no state
  obc_byte_decode u_dec
  (
    .byte0_i(r.bytes[0]),
    .byte1_i(r.bytes[1]),
    .byte2_i(r.bytes[2]),
    .byte3_i(r.bytes[3]),
    .byte4_i(r.bytes[4]),
    .cfg_o(dec_cfg),
    .pattern_err_o(pattern_err)
  );

  // Word index to read value
  function automatic logic [31:0] reg_read(input logic [`OBC_WB_ADDR_W-1:0] a,
                                           input obc_regs_t s, input logic perr);
    case (a)
      `OBC_REG_WDT: reg_read = {24'h000000, s.bytes[0]};
      `OBC_REG_LVD: reg_read = {24'h000000, s.bytes[1]};
      `OBC_REG_FOSC: reg_read = {24'h000000, s.bytes[2]};
      `OBC_REG_DBGPIN: reg_read = {24'h000000, s.bytes[3]};
      `OBC_REG_DBGCTL: reg_read = {24'h000000, s.bytes[4]};
      `OBC_REG_STATUS: reg_read = {29'h00000000, perr, s.swap, s.valid};
      default: reg_read = 32'h00000000;
    endcase
  endfunction : reg_read

  function automatic logic reg_hit(input logic [`OBC_WB_ADDR_W-1:0] a);
    reg_hit = (a >= `OBC_REG_WDT && a <= `OBC_REG_DBGCTL) || a == `OBC_REG_STATUS;
  endfunction : reg_hit

  // Fetch sequence and bus slave
  always_comb
  begin
    next_r = r;
    next_r.ack = 1'b0;
    next_r.err = 1'b0;
    case (r.state)
      OBC_IDLE:
      begin
        next_r.swap = boot_swap_i;
        next_r.idx = 3'h0;
        next_r.state = OBC_REQ;
      end
      OBC_REQ:
      begin
        next_r.state = OBC_WAIT;
      end
      OBC_WAIT:
      begin
        if (flash_rsp_i.ready)
        begin
          next_r.bytes[r.idx] = flash_rsp_i.data;
          if (r.idx == `OBC_NUM_BYTES - 3'h1)
          begin
            next_r.state = OBC_DONE;
            next_r.valid = 1'b1;
          end
          else
          begin
            next_r.idx = r.idx + 3'h1;
            next_r.state = OBC_REQ;
          end
        end
      end
      OBC_DONE:
      begin
        next_r.state = OBC_DONE;
      end
      default:
      begin
        next_r.state = OBC_IDLE;
      end
    endcase
    // One-cycle answer; ack drops the cycle after it was given
    if (wb_cyc_i && wb_stb_i && !r.ack && !r.err)
    begin
      if (!wb_we_i && reg_hit(wb_adr_i))
      begin
        next_r.ack = 1'b1;
        next_r.rdat = reg_read(wb_adr_i, r, pattern_err);
      end
      else
      begin
        next_r.err = 1'b1; // Read-only map: writes and holes are errors
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r.state <= OBC_IDLE;
      r.idx <= 3'h0;
      r.swap <= 1'b0;
      r.bytes <= {5{`OBC_BYTE_RST}};
      r.valid <= 1'b0;
      r.ack <= 1'b0;
      r.err <= 1'b0;
      r.rdat <= 32'h00000000;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Flash address: primary or alternate base plus index
  assign flash_req_o.rd = (r.state == OBC_REQ);
  assign flash_req_o.addr = (r.swap ? `OBC_ALT_BASE : `OBC_PRI_BASE) + {13'h0000, r.idx};

  // Settings before the fetch ends read as all zero
  assign cfg_o = r.valid ? dec_cfg : '0;
  assign cfg_valid_o = r.valid;

  // Slow oscillator stops only when unlocked and requested
  assign slow_osc_run_o = !(r.valid && !cfg_o.slow_osc_lock && slow_osc_stop_req_i);
  // Flash self-programming deliberately not a gating term
  assign wdt_clk_en_o = cfg_o.wdt_run_enable && slow_osc_run_o
    && !(!cfg_o.slow_osc_lock && (halt_i || stop_i));

  // Voltage default write: programmer only, never self-programming
  assign lvd_wr_allow_o = lvd_wr_req_i && ext_prog_mode_i && !flash_selfprog_i
    && chip_erased_i;
  // Swap carries alternate byte1 into the primary slot
  assign swap_copy_o = r.swap && r.valid;

  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;
  assign wb_err_o = r.err;

  // Checks
  sequence s_fetch_step;
    r.state == OBC_WAIT && flash_rsp_i.ready;
  endsequence

  chk_addr_base: assert property (@(posedge clk_i) disable iff (rst_i)
    flash_req_o.rd |-> flash_req_o.addr[15:3] == (r.swap ? 13'h0210 : 13'h0010))
    else $error("flash address outside option area");
  chk_cfg_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_valid_o |=> cfg_valid_o && $stable(cfg_o))
    else $error("settings changed after fetch");
  chk_fetch_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_fetch_step and r.idx == 3'h4) |=> cfg_valid_o)
    else $error("valid not raised after fifth byte");
  chk_idx_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_fetch_step and r.idx != 3'h4) |=> r.idx == $past(r.idx) + 3'h1)
    else $error("byte index did not advance");
  chk_wdt_halt: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg_valid_o && !cfg_o.slow_osc_lock && (halt_i || stop_i)) |-> !wdt_clk_en_o)
    else $error("watchdog clocked in low power while stoppable");
  chk_wdt_prog: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg_o.wdt_run_enable && slow_osc_run_o && !halt_i && !stop_i) |-> wdt_clk_en_o)
    else $error("watchdog clock gated without cause");
  chk_wdt_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_o.wdt_run_enable |-> !wdt_clk_en_o)
    else $error("watchdog counts while disabled");
  chk_osc_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg_valid_o && cfg_o.slow_osc_lock) |-> slow_osc_run_o)
    else $error("locked slow oscillator stopped");
  chk_lvd_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    lvd_wr_allow_o |-> ext_prog_mode_i && !flash_selfprog_i && chip_erased_i)
    else $error("voltage default write outside programmer");
  chk_win_map: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_valid_o |-> cfg_o.wdt_window == obc_win_t'(r.bytes[0][6:5]))
    else $error("window field mismatch");
  chk_ovf_map: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg_valid_o && r.bytes[0][3:1] == 3'h7) |-> cfg_o.wdt_ovf_log2 == 5'h11)
    else $error("longest overflow wrong");
  chk_dbg_map: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_o.debug_erase_on_fail |-> cfg_o.debug_enable)
    else $error("erase policy without debug enable");
  chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule : obc_loader

// ===== sim/obc_flash_model.sv
/*
  Behavioural flash array holding primary and alternate configuration images.
  Assumes one read request pulse at a time from the loader; latency set by lat_i.
*/
`timescale 1ns/1ps
module obc_flash_model
  import obc_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input obc_pkg::obc_flash_req_t req_i, // Byte read request
  output obc_pkg::obc_flash_rsp_t rsp_o, // Byte answer
  input wire logic [39:0] pri_i, // Primary image, byte 0 lowest
  input wire logic [39:0] alt_i, // Alternate image
  input wire logic [1:0] lat_i // Extra wait cycles
);
  import obc_pkg::*;
  logic [15:0] adr;
  logic [1:0] cnt;
  logic busy;
  logic [7:0] last;
  logic [7:0] rbyte;
  // Image select from base; other addresses give junk, not a stale byte
  always_comb
  begin
    rbyte = ~last;
    if (adr[2:0] < 3'h5 && adr[15:3] == 13'h0010)
      rbyte = pri_i[8*adr[2:0] +: 8];
    if (adr[2:0] < 3'h5 && adr[15:3] == 13'h0210)
      rbyte = alt_i[8*adr[2:0] +: 8];
  end
  // Answer lat_i+1 cycles after the request; data line inverted when not answering
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy <= 1'b0;
      rsp_o <= '0;
      last <= 8'h00;
    end
    else
    begin
      rsp_o.ready <= 1'b0;
      rsp_o.data <= ~last;
      if (req_i.rd)
      begin
        busy <= 1'b1;
        cnt <= lat_i;
        adr <= req_i.addr;
      end
      else if (busy && cnt != 2'h0)
        cnt <= cnt - 2'h1;
      else if (busy)
      begin
        busy <= 1'b0;
        rsp_o.ready <= 1'b1;
        rsp_o.data <= rbyte;
        last <= rbyte;
      end
    end
  end
endmodule : obc_flash_model

// ===== sim/tb_top.sv
/*
  Testbench for the configuration byte loader: decode table, boot swap,
  gating, write gate and Wishbone read-back.
  Assumes the flash model in obc_flash_model.sv.
*/
`timescale 1ns/1ps
module tb_top;
  import obc_pkg::*;
  logic clk, rst, swap, halt, stop, sreq, sp, ext, erased, lreq, cyc, stb, we;
  logic [7:0] adr;
  logic [1:0] lat, w, dbg;
  logic [39:0] pri, alt, img;
  logic [31:0] rdat, d;
  logic valid, run, wclk, allow, copy, ack, werr, e, en, lock, rq;
  obc_flash_req_t req;
  obc_flash_rsp_t rsp;
  obc_cfg_t cfg, exp;
  int err_count, n_checks, n;
  localparam logic [4:0] OVF [8] = '{5'h07, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0e, 5'h0f, 5'h11};
  localparam logic [1:0] DBG [3] = '{2'h0, 2'h2, 2'h3};

  obc_loader obc_loader_inst (.clk_i(clk), .rst_i(rst), .boot_swap_i(swap),
    .flash_req_o(req), .flash_rsp_i(rsp), .cfg_valid_o(valid), .cfg_o(cfg),
    .halt_i(halt), .stop_i(stop), .slow_osc_stop_req_i(sreq), .flash_selfprog_i(sp),
    .slow_osc_run_o(run), .wdt_clk_en_o(wclk), .ext_prog_mode_i(ext),
    .chip_erased_i(erased), .lvd_wr_req_i(lreq), .lvd_wr_allow_o(allow),
    .swap_copy_o(copy), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(32'hffffffff), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(werr));
  obc_flash_model obc_flash_model_inst (.clk_i(clk), .rst_i(rst), .req_i(req),
    .rsp_o(rsp), .pri_i(pri), .alt_i(alt), .lat_i(lat));

  // Clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] expv);
    n_checks++;
    if (got !== expv)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, expv);
    end
  endtask : chk_val

  task automatic chk_cfg(input obc_cfg_t got, input obc_cfg_t expv);
    chk_val(32'(got), 32'(expv));
  endtask : chk_cfg

  // One classic Wishbone cycle; waits for ack or err under a bound
  task automatic wb_xfer(input logic wr, input logic [7:0] a, output logic [31:0] dat,
                         output logic er);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && werr !== 1'b1 && k < 50);
    dat = rdat;
    er = werr;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50)
      err_count++;
  endtask : wb_xfer

  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Hang guard, well beyond eight loads with their sweeps
  initial
  begin
    #(40 * 20000);
    err_count++;
    end_sim();
  end

  initial
  begin
    {rst, swap, halt, stop, sreq, sp, ext, erased, lreq, cyc, stb, we} = 12'h800;
    adr = 8'h00;
    lat = 2'h0;
    pri = '0;
    alt = '0;
    err_count = 0;
    n_checks = 0;
    for (int i = 0; i < 8; i++)
    begin
      // Legal image: bit 7 clear, no 000/00 pair, fixed bits kept
      w = ~i[1:0];
      en = i[0] ^ i[1];
      lock = i[0];
      dbg = DBG[i % 3];
      img = {6'h00, dbg, 8'h1c | {6'h00, i[0] ^ i[2], 1'b0}, 7'h00, i[2], 7'h00, i[1],
             1'b0, w, en, i[2:0], lock};
      @(posedge clk);
      rst <= 1'b1;
      swap <= i[1];
      lat <= 2'(i % 3);
      pri <= i[1] ? ~img : img;
      alt <= i[1] ? img : ~img;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk_val(valid, 1'b0);
      chk_cfg(cfg, '0);
      n = 0;
      while (valid !== 1'b1 && n < 200)
      begin
        @(posedge clk);
        n++;
      end
      @(negedge clk);
      chk_val(valid, 1'b1);
      exp = '0;
      exp.wdt_window = obc_win_t'(w); // Expected settings from the image
      exp.wdt_run_enable = en;
      exp.wdt_period_sel = 3'(i);
      exp.wdt_ovf_log2 = OVF[i];
      exp.slow_osc_lock = lock;
      exp.voltage_detect_default_on = i[1];
      exp.fast_osc_freq_sel = i[2];
      exp.debug_pin_pair_sel = i[0] ^ i[2];
      exp.debug_mode = obc_dbg_t'(dbg);
      exp.debug_enable = dbg[1];
      exp.debug_erase_on_fail = dbg[1] & dbg[0];
      chk_cfg(cfg, exp);
      chk_val(copy, i[1]);
      // Register read-back, refused write and unmapped read
      for (int k = 0; k < 5; k++)
      begin
        wb_xfer(1'b0, 8'h80 + 8'(k), d, e);
        chk_val(d, {24'h0, img[8*k +: 8]});
        chk_val(e, 1'b0);
      end
      wb_xfer(1'b1, 8'h80, d, e);
      chk_val(e, 1'b1);
      wb_xfer(1'b0, 8'h85, d, e);
      chk_val(e, 1'b1);
      wb_xfer(1'b0, 8'h90, d, e);
      chk_val(d, {29'h0, 1'b0, i[1], 1'b1});
      chk_val(e, 1'b0);
      // Sweep power modes, stop request, self-programming and write gate
      for (int j = 0; j < 16; j++)
      begin
        @(posedge clk);
        {halt, stop, sreq, sp} <= 4'(j);
        {erased, ext, lreq} <= 3'(j >> 1);
        @(negedge clk);
        rq = lock | ~sreq;
        chk_val(run, rq);
        chk_val(wclk, en & rq & ~(~lock & (halt | stop)));
        chk_val(allow, lreq & ext & ~sp & erased);
      end
      chk_cfg(cfg, exp);
    end
    // Pattern flag: overflow 100 with window 00 is legal, 000 with 00 is not
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      rst <= 1'b1;
      swap <= 1'b0;
      pri <= {8'h00, 8'h1c, 16'h0000, i[0] ? 8'h00 : 8'h08};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      n = 0;
      while (valid !== 1'b1 && n < 200)
      begin
        @(posedge clk);
        n++;
      end
      chk_val(valid, 1'b1);
      wb_xfer(1'b0, 8'h90, d, e);
      chk_val(d, {29'h0, i[0], 1'b0, 1'b1});
    end
    end_sim();
  end
endmodule : tb_top
